// File: verilog/cos_semantics.sv
// operand semantics unit: classifies one instruction, resolves same-register
// side effects, pc stores, autoincrement jump targets, illegal jump traps, and guards the
// general-register bus window.
// assumes the core presents register values of the src and dst fields in the
// same cycle as the instruction; results follow one clock later.
`timescale 1ns/1ps
`default_nettype none
`include "cos_cfg.svh"

module cos_semantics
  import cos_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // instruction in
  input wire logic dec_valid_i,
  input wire logic [15:0] instr_i,
  input wire logic [15:0] instr_addr_i,
  input wire logic [15:0] src_reg_val_i,
  input wire logic [15:0] dst_reg_val_i,
  // bus address check in
  input wire logic bus_req_i,
  input wire logic [15:0] bus_addr_i,
  input wire logic bus_console_i,
  // decode result out
  output logic dec_valid_o,
  output cos_dec_s dec_o,
  // bus check out
  output logic bus_chk_valid_o,
  output logic bus_timeout_o
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic is_inc(input logic [2:0] m);
    is_inc = (m == `COS_M_AINC) || (m == `COS_M_AINCD);
  endfunction

  function automatic logic is_dec(input logic [2:0] m);
    is_dec = (m == `COS_M_ADEC) || (m == `COS_M_ADECD);
  endfunction

  // byte ops step by one except on sp and pc, which stay word aligned
  function automatic logic [15:0] step_of(input logic byte_op,
                                          input logic [2:0] r);
    step_of = (byte_op && r != `COS_REG_SP && r != `COS_REG_PC) ?
              `COS_STEP_BYTE : `COS_STEP_WORD;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // field split and class decode

  logic [2:0] smode, sreg, dmode, dreg;
  logic byte_op;
  cos_class_e cls;

  assign smode = instr_i[`COS_SRC_MODE];
  assign sreg = instr_i[`COS_SRC_REG];
  assign dmode = instr_i[`COS_DST_MODE];
  assign dreg = instr_i[`COS_DST_REG];
  // code 6 with the top bit set is the word subtract, not a byte op
  assign byte_op = instr_i[`COS_BYTE_BIT] &&
                   (instr_i[`COS_TWO_OP] != `COS_TWO_HI);

  always_comb begin
    cls = COS_OTHER;
    if (instr_i[`COS_TOP4] == `COS_OP_FP) begin
      cls = COS_FLOAT;
    end else if (instr_i[`COS_TWO_OP] >= `COS_TWO_LO &&
                 instr_i[`COS_TWO_OP] <= `COS_TWO_HI) begin
      cls = COS_TWO_OPERAND_INSTR;
    end else if (instr_i == `COS_OP_TRET) begin
      cls = COS_TRACE_RETURN_INSTR;
    end else begin
      case (instr_i[`COS_TOP10])
        `COS_OP_JUMP: cls = COS_JUMP_INSTR;
        `COS_OP_SWAP: cls = COS_BYTE_SWAP_INSTR;
        `COS_OP_MARK: cls = COS_STACK_MARK;
        `COS_OP_SEXT: cls = COS_SIGN_EXTEND_INSTR;
        default: begin
          case (instr_i[`COS_TOP7])
            `COS_OP_CALL: cls = COS_SUBROUTINE_CALL_INSTR;
            `COS_OP_MUL: cls = COS_MULTIPLY;
            `COS_OP_DIV: cls = COS_DIVIDE;
            `COS_OP_ASH: cls = COS_ARITH_SHIFT_INSTR;
            `COS_OP_ARITH_SHIFT_COMBINED_INSTR: cls = COS_ARITH_SHIFT_COMBINED_INSTR;
            `COS_OP_XOR: cls = COS_EXCL_OR;
            `COS_OP_DECBR: cls = COS_DECREMENT_BRANCH_INSTR;
            default: cls = COS_OTHER;
          endcase
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // operand semantics

  cos_dec_s dec_nxt;
  logic [15:0] step;
  logic same_reg;
  logic is_jmp;

  assign step = step_of(byte_op, dreg);
  assign same_reg = (sreg == dreg);
  assign is_jmp = (cls == COS_JUMP_INSTR) ||
                  (cls == COS_SUBROUTINE_CALL_INSTR);

  always_comb begin
    dec_nxt = '0;
    dec_nxt.cls = cls;
    dec_nxt.src_val = src_reg_val_i;
    dec_nxt.reg_idx = dreg;
    dec_nxt.reg_val = dst_reg_val_i;
    if (cls == COS_TWO_OPERAND_INSTR) begin
      // destination side effect is visible to a plain register source
      if (is_inc(dmode) || is_dec(dmode)) begin
        dec_nxt.reg_we = 1'b1;
        dec_nxt.reg_val = is_inc(dmode) ? dst_reg_val_i + step
                                        : dst_reg_val_i - step;
        if (smode == `COS_M_REG && same_reg) begin
          dec_nxt.src_val = dec_nxt.reg_val;
        end
      end
      if (smode == `COS_M_REG && sreg == `COS_REG_PC) begin
        // index word already fetched when pc is stored
        dec_nxt.src_val = (dmode == `COS_M_IDX || dmode == `COS_M_IDXD) ?
                          instr_addr_i + `COS_PC_OFS_IDX :
                          instr_addr_i + `COS_PC_OFS_NEXT;
      end
    end
    if (is_jmp) begin
      if (dmode == `COS_M_REG) begin
        dec_nxt.trap = 1'b1;
        dec_nxt.vector = `COS_VEC_ILL;
      end else if (dmode == `COS_M_AINC) begin
        dec_nxt.target = dst_reg_val_i;
        dec_nxt.target_ok = 1'b1;
        dec_nxt.reg_we = 1'b1;
        dec_nxt.reg_val = dst_reg_val_i + `COS_STEP_WORD;
      end
    end
    if (cls == COS_BYTE_SWAP_INSTR) begin
      dec_nxt.swap_res = {dst_reg_val_i[7:0], dst_reg_val_i[15:8]};
      dec_nxt.flags = {dst_reg_val_i[15], dst_reg_val_i[15:8] == 8'h00,
                       1'b0, 1'b0};
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      dec_valid_o <= 1'b0;
      dec_o <= '0;
    end else begin
      dec_valid_o <= dec_valid_i;
      if (dec_valid_i) begin
        dec_o <= dec_nxt;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus window guard; console accesses get no exemption

  logic greg_hit;

  cos_addr_guard u_guard (
    .addr_i(bus_addr_i),
    .hit_o(greg_hit)
  );

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      bus_chk_valid_o <= 1'b0;
      bus_timeout_o <= 1'b0;
    end else begin
      bus_chk_valid_o <= bus_req_i;
      bus_timeout_o <= bus_req_i && greg_hit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  sequence seq_jump_ainc;
    dec_valid_i && is_jmp && dmode == `COS_M_AINC;
  endsequence

  sequence seq_jump_done(logic [15:0] v);
    dec_valid_o && dec_o.target_ok && dec_o.target == v &&
    dec_o.reg_val == v + `COS_STEP_WORD;
  endsequence

  sequence seq_bus_win;
    bus_req_i && bus_addr_i >= `COS_GREG_LO && bus_addr_i <= `COS_GREG_HI;
  endsequence

  AST_SAME_REG_INC: assert property (
    dec_valid_i && cls == COS_TWO_OPERAND_INSTR && smode == `COS_M_REG &&
    same_reg && dmode == `COS_M_AINC && sreg != `COS_REG_PC && !byte_op
    |=> dec_o.src_val == $past(dst_reg_val_i) + `COS_STEP_WORD &&
        dec_o.reg_we)
    else $error("register source not stepped before use");

  AST_SAME_REG_DEFER: assert property (
    dec_valid_i && cls == COS_TWO_OPERAND_INSTR && smode == `COS_M_REG &&
    same_reg && dmode == `COS_M_ADECD && sreg != `COS_REG_PC && !byte_op
    |=> dec_o.src_val == $past(dst_reg_val_i) - `COS_STEP_WORD)
    else $error("deferred destination step not seen by source");

  AST_PC_STORE: assert property (
    dec_valid_i && cls == COS_TWO_OPERAND_INSTR && smode == `COS_M_REG &&
    sreg == `COS_REG_PC && (dmode == `COS_M_IDX || dmode == `COS_M_IDXD)
    |=> dec_o.src_val == $past(instr_addr_i) + `COS_PC_OFS_IDX)
    else $error("stored pc is not instruction address plus four");

  AST_JUMP_TARGET: assert property (
    seq_jump_ainc |=> seq_jump_done($past(dst_reg_val_i)))
    else $error("jump target is not the unstepped register value");

  AST_ILLEGAL_JUMP: assert property (
    dec_valid_i && is_jmp && dmode == `COS_M_REG
    |=> dec_o.trap && dec_o.vector == `COS_VEC_ILL && !dec_o.reg_we &&
        !dec_o.target_ok)
    else $error("register-mode jump did not trap to four");

  AST_GREG_TIMEOUT: assert property (
    seq_bus_win |=> bus_timeout_o && bus_chk_valid_o)
    else $error("general-register window access did not time out");

  AST_NO_FALSE_TIMEOUT: assert property (
    bus_timeout_o |-> $past(bus_req_i) && $past(greg_hit))
    else $error("timeout outside the general-register window");

  AST_CONSOLE_TIMEOUT: assert property (
    bus_req_i && bus_console_i && greg_hit |=> bus_timeout_o)
    else $error("console access to register window did not time out");

  AST_FP_NATIVE: assert property (
    dec_valid_i && instr_i[`COS_TOP4] == `COS_OP_FP
    |=> dec_o.cls == COS_FLOAT && !dec_o.trap)
    else $error("floating-point opcode not decoded natively");

  AST_EXT_DECODE: assert property (
    dec_valid_i && instr_i[`COS_TOP7] == `COS_OP_DECBR
    |=> dec_o.cls == COS_DECREMENT_BRANCH_INSTR && dec_valid_o &&
        !dec_o.trap)
    else $error("decrement-and-branch not decoded");

  AST_SWAP_FLAGS: assert property (
    dec_valid_i && cls == COS_BYTE_SWAP_INSTR
    |=> dec_o.flags[1] == 1'b0 &&
        dec_o.flags[2] == (dec_o.swap_res[7:0] == 8'h00) &&
        dec_o.flags[3] == dec_o.swap_res[7])
    else $error("byte swap flags wrong");

endmodule
`default_nettype wire

// File: verilog/cos_cfg.svh
// constants for the operand semantics unit: field positions, codes, offsets
// assumes 16-bit instruction words with octal-style 3-bit mode/reg fields
`ifndef COS_CFG_SVH
`define COS_CFG_SVH

`define COS_W 16
// operand field positions
`define COS_SRC_MODE 11:9
`define COS_SRC_REG 8:6
`define COS_DST_MODE 5:3
`define COS_DST_REG 2:0
`define COS_BYTE_BIT 15
`define COS_TWO_OP 14:12
`define COS_TOP10 15:6
`define COS_TOP7 15:9
`define COS_TOP4 15:12
// addressing modes
`define COS_M_REG 3'h0
`define COS_M_AINC 3'h2
`define COS_M_AINCD 3'h3
`define COS_M_ADEC 3'h4
`define COS_M_ADECD 3'h5
`define COS_M_IDX 3'h6
`define COS_M_IDXD 3'h7
`define COS_REG_PC 3'h7
`define COS_REG_SP 3'h6
// opcode patterns
`define COS_TWO_LO 3'h1
`define COS_TWO_HI 3'h6
`define COS_OP_JUMP 10'h001
`define COS_OP_SWAP 10'h003
`define COS_OP_MARK 10'h034
`define COS_OP_SEXT 10'h037
`define COS_OP_CALL 7'h04
`define COS_OP_MUL 7'h38
`define COS_OP_DIV 7'h39
`define COS_OP_ASH 7'h3a
`define COS_OP_ARITH_SHIFT_COMBINED_INSTR 7'h3b
`define COS_OP_XOR 7'h3c
`define COS_OP_DECBR 7'h3f
`define COS_OP_FP 4'hf
`define COS_OP_TRET 16'h0006
// offsets and steps
`define COS_STEP_WORD 16'h0002
`define COS_STEP_BYTE 16'h0001
`define COS_PC_OFS_IDX 16'h0004
`define COS_PC_OFS_NEXT 16'h0002
`define COS_VEC_ILL 8'h04
// general-register window on the bus
`define COS_GREG_LO 16'hffc0
`define COS_GREG_HI 16'hffcf

`endif

// File: verilog/cos_pkg.sv
// types shared by the operand semantics unit
// assumes cos_cfg.svh supplies the numeric constants
package cos_pkg;

  typedef enum logic [3:0] {
    COS_OTHER,
    COS_TWO_OPERAND_INSTR,
    COS_JUMP_INSTR,
    COS_SUBROUTINE_CALL_INSTR,
    COS_BYTE_SWAP_INSTR,
    COS_DECREMENT_BRANCH_INSTR,
    COS_STACK_MARK,
    COS_TRACE_RETURN_INSTR,
    COS_SIGN_EXTEND_INSTR,
    COS_ARITH_SHIFT_INSTR,
    COS_ARITH_SHIFT_COMBINED_INSTR,
    COS_DIVIDE,
    COS_MULTIPLY,
    COS_EXCL_OR,
    COS_FLOAT
  } cos_class_e;

  // flags ordered n, z, v, c
  typedef struct packed {
    cos_class_e cls;
    logic trap;
    logic [7:0] vector;
    logic [15:0] src_val;
    logic [15:0] target;
    logic target_ok;
    logic reg_we;
    logic [2:0] reg_idx;
    logic [15:0] reg_val;
    logic [15:0] swap_res;
    logic [3:0] flags;
  } cos_dec_s;

endpackage

// File: verilog/cos_addr_guard.sv
// address window check for the general-register range
// assumes a 16-bit address from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
`include "cos_cfg.svh"

module cos_addr_guard #(
  parameter logic [15:0] LO = `COS_GREG_LO,
  parameter logic [15:0] HI = `COS_GREG_HI
) (
  // address in
  input wire logic [15:0] addr_i,
  // window hit
  output logic hit_o
);

  assign hit_o = (addr_i >= LO) && (addr_i <= HI);

endmodule
`default_nettype wire

// File: verif/cos_mem_model.sv
// memory side of the bus check: answers every address but the register window
// assumes the unit's check result is presented one cycle after a request
`timescale 1ns/1ps
`default_nettype none

module cos_mem_model (
  // check result in
  input wire logic chk_valid_i,
  input wire logic timeout_i,
  // memory answer out
  output logic ack_o
);
  // window hits are never decoded, so no answer and the cycle times out
  assign ack_o = chk_valid_i & ~timeout_i;
endmodule

`default_nettype wire

// File: verif/testbench.sv
// self-checking bench for the operand semantics unit
// assumes cos_pkg, cos_semantics and cos_mem_model are compiled first
`timescale 1ns/1ps
`default_nettype none

module testbench
  import cos_pkg::*;
;
  logic clk_i, rst_b_i, dec_valid_i, bus_req_i, bus_console_i, mem_ack;
  logic [15:0] instr_i, instr_addr_i, src_reg_val_i, dst_reg_val_i;
  logic [15:0] bus_addr_i;
  logic dec_valid_o, bus_chk_valid_o, bus_timeout_o;
  cos_dec_s dec_o;
  int fail_count = 0;
  int tests_run = 0;
  int cyc = 0;

  cos_semantics i_dut (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .dec_valid_i(dec_valid_i),
    .instr_i(instr_i), .instr_addr_i(instr_addr_i),
    .src_reg_val_i(src_reg_val_i), .dst_reg_val_i(dst_reg_val_i),
    .bus_req_i(bus_req_i), .bus_addr_i(bus_addr_i),
    .bus_console_i(bus_console_i), .dec_valid_o(dec_valid_o),
    .dec_o(dec_o), .bus_chk_valid_o(bus_chk_valid_o),
    .bus_timeout_o(bus_timeout_o)
  );
  cos_mem_model i_mem (
    .chk_valid_i(bus_chk_valid_o), .timeout_i(bus_timeout_o),
    .ack_o(mem_ack)
  );

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ceiling well above the 38 or so cycles the tests need
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 2000) begin
      fail_count++;
      $display("[ERR] %0t run hung", $time);
      finish_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string what);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // valid is left high so calls run back to back
  task automatic dec(input logic [15:0] ins, input logic [15:0] ia,
                     input logic [15:0] sv, input logic [15:0] dv);
    dec_valid_i = 1'b1;
    instr_i = ins;
    instr_addr_i = ia;
    src_reg_val_i = sv;
    dst_reg_val_i = dv;
    @(posedge clk_i);
    #1;
    chk({15'h0, dec_valid_o}, 16'h1, "dec valid");
  endtask

  task automatic bus(input logic [15:0] a, input logic con,
                     input logic exp);
    bus_req_i = 1'b1;
    bus_addr_i = a;
    bus_console_i = con;
    @(posedge clk_i);
    #1;
    chk({15'h0, bus_chk_valid_o}, 16'h1, "chk valid");
    chk({15'h0, bus_timeout_o}, {15'h0, exp}, "timeout");
    chk({15'h0, mem_ack}, {15'h0, ~exp}, "mem ack");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_same_reg();
    // word subtract steps by two; byte move on r1 steps by one
    logic [15:0] ins [6] = '{16'h1051, 16'h1061, 16'h1059, 16'h1069,
      16'he051, 16'h9051};
    logic [15:0] exp [6] = '{16'h1002, 16'h0ffe, 16'h1002, 16'h0ffe,
      16'h1002, 16'h1001};
    for (int i = 0; i < 6; i++) begin
      dec(ins[i], 16'h0100, 16'h1000, 16'h1000);
      chk(dec_o.src_val, exp[i], "stepped src");
      chk(dec_o.reg_val, exp[i], "stepped reg");
      chk({15'h0, dec_o.reg_we}, 16'h1, "reg we");
      chk({13'h0, dec_o.reg_idx}, 16'h0001, "reg idx");
    end
    $display("test same_reg done");
  endtask

  task automatic t_pc_store();
    logic [15:0] ins [4] = '{16'h11f3, 16'h11fb, 16'h11f7, 16'h11d3};
    logic [15:0] exp [4] = '{16'h0204, 16'h0204, 16'h0204, 16'h0202};
    for (int i = 0; i < 4; i++) begin
      dec(ins[i], 16'h0200, 16'h0202, 16'h0400);
      chk(dec_o.src_val, exp[i], "pc store");
    end
    $display("test pc_store done");
  endtask

  task automatic t_jump();
    logic [15:0] ins [2] = '{16'h0053, 16'h09d3};
    logic [15:0] bad [2] = '{16'h0043, 16'h09c3};
    cos_class_e jc [2] = '{COS_JUMP_INSTR, COS_SUBROUTINE_CALL_INSTR};
    for (int i = 0; i < 2; i++) begin
      dec(ins[i], 16'h0300, 16'h0000, 16'h3000);
      chk({12'h0, dec_o.cls}, {12'h0, jc[i]}, "jump class");
      chk(dec_o.target, 16'h3000, "target");
      chk({15'h0, dec_o.target_ok}, 16'h1, "target ok");
      chk({15'h0, dec_o.trap}, 16'h0, "no trap");
      chk(dec_o.reg_val, 16'h3002, "reg stepped after");
      chk({15'h0, dec_o.reg_we}, 16'h1, "reg we");
      dec(bad[i], 16'h0300, 16'h0000, 16'h3000);
      chk({15'h0, dec_o.trap}, 16'h1, "trap");
      chk({8'h0, dec_o.vector}, 16'h0004, "vector");
      chk({15'h0, dec_o.reg_we}, 16'h0, "no writeback");
      chk({15'h0, dec_o.target_ok}, 16'h0, "no target");
    end
    $display("test jump done");
  endtask

  task automatic t_classes();
    logic [15:0] ins [10] = '{16'hf000, 16'h7000, 16'h7200, 16'h7400,
      16'h7600, 16'h7800, 16'h7e00, 16'h0d00, 16'h0dc0, 16'h0006};
    cos_class_e cl [10] = '{COS_FLOAT, COS_MULTIPLY, COS_DIVIDE,
      COS_ARITH_SHIFT_INSTR, COS_ARITH_SHIFT_COMBINED_INSTR, COS_EXCL_OR,
      COS_DECREMENT_BRANCH_INSTR, COS_STACK_MARK, COS_SIGN_EXTEND_INSTR,
      COS_TRACE_RETURN_INSTR};
    for (int i = 0; i < 10; i++) begin
      dec(ins[i], 16'h0100, 16'h0000, 16'h0000);
      chk({12'h0, dec_o.cls}, {12'h0, cl[i]}, "class");
      chk({15'h0, dec_o.trap}, 16'h0, "no trap");
    end
    $display("test classes done");
  endtask

  task automatic t_swap();
    logic [15:0] dv [3] = '{16'h1280, 16'h8000, 16'h00ab};
    logic [15:0] res [3] = '{16'h8012, 16'h0080, 16'hab00};
    logic [3:0] fl [3] = '{4'h0, 4'h8, 4'h4};
    for (int i = 0; i < 3; i++) begin
      dec(16'h00c1, 16'h0100, 16'h0000, dv[i]);
      chk({12'h0, dec_o.cls}, {12'h0, COS_BYTE_SWAP_INSTR}, "swap cls");
      chk(dec_o.swap_res, res[i], "swap");
      chk({12'h0, dec_o.flags}, {12'h0, fl[i]}, "swap flags");
    end
    $display("test swap done");
  endtask

  task automatic t_bus();
    bus(16'hffbf, 1'b0, 1'b0);
    bus(16'hffc0, 1'b0, 1'b1);
    bus(16'hffcf, 1'b0, 1'b1);
    bus(16'hffc4, 1'b1, 1'b1);
    bus(16'hffd0, 1'b1, 1'b0);
    $display("test bus done");
  endtask

  initial begin
    rst_b_i = 1'b0;
    dec_valid_i = 1'b0;
    instr_i = 16'h0;
    instr_addr_i = 16'h0;
    src_reg_val_i = 16'h0;
    dst_reg_val_i = 16'h0;
    bus_req_i = 1'b0;
    bus_addr_i = 16'h0;
    bus_console_i = 1'b0;
    repeat (5) @(posedge clk_i);
    #1;
    rst_b_i = 1'b1;
    chk({15'h0, dec_valid_o}, 16'h0, "reset valid");
    chk(dec_o.reg_val, 16'h0, "reset dec");
    t_same_reg();
    t_pc_store();
    t_jump();
    t_classes();
    t_swap();
    dec_valid_i = 1'b0;
    t_bus();
    bus_req_i = 1'b0;
    @(posedge clk_i);
    #1;
    chk({15'h0, dec_valid_o}, 16'h0, "valid pulse");
    chk({15'h0, bus_chk_valid_o}, 16'h0, "chk pulse");
    finish_test();
  end
endmodule

`default_nettype wire
